// ===== dv/sstm_monitor_chk.sv
// Port-level assertions for the safety monitor.
`timescale 1ns/1ps
module sstm_monitor_chk (
  input wire        REF_CLK,
  input wire        NRST,
  input wire        WB_WE_I,
  input wire        WB_CYC_I,
  input wire        WB_STB_I,
  input wire        WB_ACK_O,
  input wire [4:0]  TEST_START,
  input wire        TEMP_SENSOR_FAIL,
  input wire        ADDER_OVF,
  input wire        CORDIC_OVF,
  input wire        DIAG_MODE,
  input wire [13:0] FLAGS
);
  // ********
  // Clocking and helpers
  // ********
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!NRST);
  // Flags that can never be masked, so they must always reach the output.
  wire hard = (|FLAGS[4:0]) || (|FLAGS[13:12]);
  // ********
  // Assertions
  // ********
  a_ack_follows: assert property (
    WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack missing after request");
  a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  a_start_onehot: assert property ($onehot0(TEST_START))
    else $error("more than one start trigger");
  a_start_ends: assert property (
    $rose(|TEST_START) |-> ##[1:210] (TEST_START == 5'h00))
    else $error("start trigger never released");
  a_adder_flag: assert property (
    $rose(ADDER_OVF) |-> ##[1:5] FLAGS[9])
    else $error("adder overflow not flagged");
  a_cordic_flag: assert property (
    $rose(CORDIC_OVF) |-> ##[1:5] FLAGS[10])
    else $error("cordic overflow not flagged");
  a_tsens_diag: assert property (
    $rose(TEMP_SENSOR_FAIL) |-> ##[2:7] (FLAGS[12] && DIAG_MODE))
    else $error("sensor failure not reported");
  a_compl_flag: assert property (
    |FLAGS[4:0] |-> ##[0:3] FLAGS[6])
    else $error("completion flag late");
  a_hard_diag: assert property (hard |-> ##[0:2] DIAG_MODE)
    else $error("unmaskable flag without diag");
  a_diag_cause: assert property (DIAG_MODE |-> $past(|FLAGS))
    else $error("diag without any flag");
  a_flag_sticky: assert property (
    |($past(FLAGS) & ~FLAGS) |-> $past(WB_CYC_I && WB_STB_I && WB_WE_I))
    else $error("flag dropped without a write");
endmodule

bind sstm_monitor sstm_monitor_chk u_chk (
  .REF_CLK(REF_CLK), .NRST(NRST), .WB_WE_I(WB_WE_I),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
  .TEST_START(TEST_START), .TEMP_SENSOR_FAIL(TEMP_SENSOR_FAIL),
  .ADDER_OVF(ADDER_OVF), .CORDIC_OVF(CORDIC_OVF),
  .DIAG_MODE(DIAG_MODE), .FLAGS(FLAGS));

// ===== dv/sstm_monitor_tb.sv
// Self-checking bench for the safety self-test monitor.
`timescale 1ns/1ps
module sstm_monitor_tb;
  reg         clk = 1'b0;
  reg         nrst = 1'b0;
  reg  [7:0]  adr = 8'h00;
  reg  [31:0] wdat = 32'h0;
  reg  [3:0]  sel = 4'h0;
  reg         we = 1'b0;
  reg         cyc = 1'b0;
  reg         stb = 1'b0;
  reg  [4:0]  rdy = 5'h00;
  reg         rdy_en = 1'b1;
  reg  [2:0]  bad = 3'd7;
  reg  [5:0]  fx = 6'h00;
  reg  [15:0] base = 16'h0100;
  reg  [4:0]  seen = 5'h00;
  reg         clr_seen = 1'b0;
  reg  [31:0] q;
  wire [31:0] rdat;
  wire        ack;
  wire [4:0]  start;
  wire        diag;
  wire [13:0] flags;
  integer     fails = 0;
  integer     n_checks = 0;
  integer     cycles = 0;
  integer     k, m, fl;
  // ********
  // Design and stimulus wiring
  // ********
  // Fault selector bad picks the one selectable check fed a wrong value.
  sstm_monitor DUT (
    .REF_CLK(clk), .NRST(nrst), .WB_ADR_I(adr), .WB_DAT_I(wdat),
    .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .TEST_START(start), .TEST_READY(rdy),
    .TEMP_SENSOR(base), .TEMP_AMPL(base + (bad == 3'd0 ? 16'h40 : 16'h0)),
    .TEMP_SENSOR_FAIL(fx[5]), .ANGLE_MAIN(base), .ANGLE_INV(16'h3000 - base),
    .CLAMP_LO(16'h0800 + {15'h0, bad == 3'd1}), .CLAMP_HI(16'h2800),
    .DIV_RESULT(16'h0040 + {15'h0, bad == 3'd2}), .CORDIC_ANGLE(base),
    .CORDIC_INV_ANGLE(16'h0 - base + {15'h0, bad == 3'd3}),
    .ANGLE_ZEROED(base), .ANGLE_ZEROED_ALU(base + {15'h0, bad == 3'd4}),
    .PATH_DONE_OK(~fx[0]), .PATH_DONE(fx[0]),
    .ADC_RESULT(fx[1] ? 16'h7fff : 16'h7990), .ADDER_OVF(fx[2]),
    .CORDIC_OVF(fx[3]), .CLAMP_SEEN(fx[4]), .RANGE_SEEN(~fx[4]),
    .DIAG_MODE(diag), .FLAGS(flags));
  // Clock of 4 ns.
  always #2 clk = ~clk;
  // Ready answers each start while rdy_en is set; the timeout guards against a hung wait.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    seen <= clr_seen ? 5'h00 : (seen | start);
    rdy <= start & {5{rdy_en}};
    if (cycles == 60000) begin
      fails = fails + 1;
      tally_and_finish;
    end
  end
  // ********
  // Tasks
  // ********
  task chk(input string s, input [31:0] e, input [31:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("MISMATCH %0s expected %h seen %h", s, e, g);
      end
    end
  endtask
  // Classic cycle; the request is held until the edge that sees ack.
  task wb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'h3;
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
    end
  endtask
  task clear_all;
    begin
      wb(1'b1, 8'h08, 32'h3fff);
      repeat (2) @(posedge clk);
    end
  endtask
  // A full sequencer round is 16 slots of 256 cycles.
  task wait_flag(input integer b);
    integer i;
    begin
      for (i = 0; i < 4400 && flags[b] !== 1'b1; i = i + 1) @(posedge clk);
      repeat (4) @(posedge clk);
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // ********
  // Tests
  // ********
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    wb(1'b0, 8'h00, 32'h0);
    chk("cfg", 32'h003f, q);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("test reset done");
    // Driven fixed checks (flags 5 and 8 to 12), each once unmasked and once masked where allowed.
    for (k = 0; k < 6; k = k + 1) begin
      fl = (k == 5) ? 12 : (k == 0 ? 5 : k + 7);
      for (m = 0; m < 2 - k / 5; m = m + 1) begin
        wb(1'b1, 8'h00, 32'h003f | (m << (fl + 3)));
        fx[k] <= 1'b1;
        repeat (4) @(posedge clk);
        fx[k] <= 1'b0;
        repeat (4) @(posedge clk);
        chk("fixed flag", 32'h1 << fl, {18'h0, flags});
        chk("fixed diag", m == 0, {31'h0, diag});
        clear_all;
        chk("cleared", 32'h0, {17'h0, diag, flags});
      end
    end
    $display("test fixed done");
    // One wrong result per selectable check.
    wb(1'b1, 8'h00, 32'h003f);
    for (k = 0; k < 5; k = k + 1) begin
      base <= base + 16'h0123;
      bad <= k[2:0];
      wait_flag(k);
      bad <= 3'd7;
      chk("sel flag", 32'h40 | (32'h1 << k), {18'h0, flags});
      chk("sel diag", 32'h1, {31'h0, diag});
      clear_all;
    end
    $display("test selectable done");
    // Global enable off, then only the division check off.
    for (m = 0; m < 2; m = m + 1) begin
      wb(1'b1, 8'h00, m ? 32'h0037 : 32'h003e);
      bad <= 3'd2;
      repeat (8) @(posedge clk);
      clr_seen <= 1'b1;
      @(posedge clk);
      clr_seen <= 1'b0;
      repeat (4400) @(posedge clk);
      chk("starts", m ? 32'h1b : 32'h0, {27'h0, seen});
      chk("no flag", 32'h0, {18'h0, flags});
      bad <= 3'd7;
    end
    $display("test enables done");
    // Starts that are never answered.
    wb(1'b1, 8'h00, 32'h003f);
    rdy_en <= 1'b0;
    wait_flag(13);
    chk("no ready", 32'h1, {31'h0, flags[13]});
    chk("no ready diag", 32'h1, {31'h0, diag});
    $display("test ready done");
    tally_and_finish;
  end
endmodule

// ===== include/sstm_regs.vh
// Register map, field positions and timing constants of the safety monitor.
`ifndef SSTM_REGS_VH
`define SSTM_REGS_VH

// ****************************************************************
// Register offsets (byte addresses, one word each)
// ****************************************************************
`define SSTM_ADR_CFG      8'h00
`define SSTM_ADR_FLAGS    8'h04
`define SSTM_ADR_CLEAR    8'h08
`define SSTM_ADR_SEQ      8'h0c
`define SSTM_ADR_W        8

// ****************************************************************
// Configuration word fields
// ****************************************************************
`define SSTM_CFG_GEN      0
`define SSTM_CFG_EN_LO    1
`define SSTM_CFG_EN_W     5
`define SSTM_CFG_MSK_LO   8
`define SSTM_CFG_MSK_W    7
`define SSTM_CFG_RST      16'h003f
`define SSTM_CFG_W        16

// ****************************************************************
// Flag word positions
// ****************************************************************
`define SSTM_F_FIELD      0
`define SSTM_F_INV        1
`define SSTM_F_DIV        2
`define SSTM_F_CONV       3
`define SSTM_F_ADJ        4
`define SSTM_F_CTRL       5
`define SSTM_F_COMPL      6
`define SSTM_F_PAR        7
`define SSTM_F_ADC        8
`define SSTM_F_ADD        9
`define SSTM_F_CORD       10
`define SSTM_F_CLAMP      11
`define SSTM_F_TSENS      12
`define SSTM_F_NORDY      13
`define SSTM_NFLAGS       14
`define SSTM_NSEL         5

// ****************************************************************
// Timing
// ****************************************************************
`define SSTM_CLK_MHZ      250
`define SSTM_COMPL_US     160
`define SSTM_SLOT_CYC     16'd256
`define SSTM_RDY_TMO      16'd200
`define SSTM_ADC_FS_PCT   95

`endif

// ===== logic/sstm_monitor.v
// Safety self-test sequencer and plausibility monitor with Wishbone access.
//
// Local design decisions: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "sstm_regs.vh"

// How it works
// - Global enable bit gates all selectable checks; clear means none start.
// - Each selectable check has its own enable bit in the config register.
// - Field check flags when sensor temperature and amplitude temperature disagree.
// - Temperature sensor failure sets a flag forcing diagnostic mode.
// - Inverted angle plus main angle must equal summed clamp levels.
// - Test division result must equal the known expected quotient.
// - Inverted CORDIC angle plus main CORDIC angle must be zero.
// - Zeroed angle must equal the redundant safety unit result.
// - Fixed diagnostics always run; flags 5 to 11 each have their own mask bit, flags 12 and 13 have none.
// - Flag raised when data path processing did not complete correctly.
// - Completion flag rises within 160 us of any selected test failure.
// - Sequencer state carries parity; mismatch sets the encoding flag.
// - Converter result above 95 percent of full scale sets overflow flag.
// - Pre-CORDIC adder overflow sets a maskable flag.
// - CORDIC internal overflow sets a maskable flag.
// - Clamp position seen before range position sets a maskable flag.
// - Sequencer is a 4-bit up-counter; slots 0 to 4 each start their own test, the others are idle.
// - Ready clears the start trigger; missing ready forces diagnostic mode.
module sstm_monitor #(
  parameter AW       = 16,
  parameter DW       = 16,
  parameter TEMP_TOL = 16'd8,
  parameter DIV_EXP  = 16'h0040,
  parameter ADC_FS   = 16'h7fff
) (
  input  wire          REF_CLK,
  input  wire          NRST,
  input  wire [7:0]    WB_ADR_I,
  input  wire [31:0]   WB_DAT_I,
  input  wire [3:0]    WB_SEL_I,
  input  wire          WB_WE_I,
  input  wire          WB_CYC_I,
  input  wire          WB_STB_I,
  output reg  [31:0]   WB_DAT_O,
  output reg           WB_ACK_O,
  output wire [4:0]    TEST_START,
  input  wire [4:0]    TEST_READY,
  input  wire [DW-1:0] TEMP_SENSOR,
  input  wire [DW-1:0] TEMP_AMPL,
  input  wire          TEMP_SENSOR_FAIL,
  input  wire [AW-1:0] ANGLE_MAIN,
  input  wire [AW-1:0] ANGLE_INV,
  input  wire [AW-1:0] CLAMP_LO,
  input  wire [AW-1:0] CLAMP_HI,
  input  wire [DW-1:0] DIV_RESULT,
  input  wire [AW-1:0] CORDIC_ANGLE,
  input  wire [AW-1:0] CORDIC_INV_ANGLE,
  input  wire [AW-1:0] ANGLE_ZEROED,
  input  wire [AW-1:0] ANGLE_ZEROED_ALU,
  input  wire          PATH_DONE_OK,
  input  wire          PATH_DONE,
  input  wire [DW-1:0] ADC_RESULT,
  input  wire          ADDER_OVF,
  input  wire          CORDIC_OVF,
  input  wire          CLAMP_SEEN,
  input  wire          RANGE_SEEN,
  output reg           DIAG_MODE,
  output wire [13:0]   FLAGS
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  reg rst_a_ff;
  reg rst_b_ff;
  wire rst_n = rst_b_ff;

  // Reset is asserted at once and released through two flops.
  always @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      rst_a_ff <= 1'b0;
      rst_b_ff <= 1'b0;
    end else begin
      rst_a_ff <= 1'b1;
      rst_b_ff <= rst_a_ff;
    end
  end

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // Status pulses from the analog path come from outside this domain.
  localparam NS = 5 + 1 + 1 + 1 + 2 + 2;
  wire [NS-1:0] async_in = {TEST_READY, TEMP_SENSOR_FAIL, ADDER_OVF,
                            CORDIC_OVF, PATH_DONE, PATH_DONE_OK,
                            CLAMP_SEEN, RANGE_SEEN};
  reg  [NS-1:0] sync_a_ff;
  reg  [NS-1:0] sync_b_ff;

  // Only the second stage is read anywhere.
  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sync_a_ff <= {NS{1'b0}};
      sync_b_ff <= {NS{1'b0}};
    end else begin
      sync_a_ff <= async_in;
      sync_b_ff <= sync_a_ff;
    end
  end

  wire [4:0] ready_s    = sync_b_ff[11:7];
  wire       tfail_s    = sync_b_ff[6];
  wire       addovf_s   = sync_b_ff[5];
  wire       cordovf_s  = sync_b_ff[4];
  wire       pdone_s    = sync_b_ff[3];
  wire       pdok_s     = sync_b_ff[2];
  wire       clamp_s    = sync_b_ff[1];
  wire       range_s    = sync_b_ff[0];

  // ****************************************************************
  // Configuration and clear registers
  // ****************************************************************
  reg  [`SSTM_CFG_W-1:0]   cfg_ff;
  reg  [`SSTM_NFLAGS-1:0]  flags_ff;
  reg  [`SSTM_NFLAGS-1:0]  clr_ff;
  wire wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire wb_wr  = wb_req & WB_WE_I;

  wire                    gen     = cfg_ff[`SSTM_CFG_GEN];
  wire [`SSTM_NSEL-1:0]   sel_en  = cfg_ff[`SSTM_CFG_EN_LO +: `SSTM_CFG_EN_W];
  wire [`SSTM_CFG_MSK_W-1:0] mask = cfg_ff[`SSTM_CFG_MSK_LO +:
                                           `SSTM_CFG_MSK_W];

  // Writes honour byte lanes; the clear register is a one-cycle strobe.
  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= `SSTM_CFG_RST;
      clr_ff <= {`SSTM_NFLAGS{1'b0}};
    end else begin
      clr_ff <= {`SSTM_NFLAGS{1'b0}};
      if (wb_wr && WB_ADR_I == `SSTM_ADR_CFG) begin
        if (WB_SEL_I[0]) cfg_ff[7:0]  <= WB_DAT_I[7:0];
        if (WB_SEL_I[1]) cfg_ff[15:8] <= WB_DAT_I[15:8];
      end else if (wb_wr && WB_ADR_I == `SSTM_ADR_CLEAR) begin
        if (WB_SEL_I[0]) clr_ff[7:0]  <= WB_DAT_I[7:0];
        if (WB_SEL_I[1]) clr_ff[13:8] <= WB_DAT_I[13:8];
      end
    end
  end

  // ****************************************************************
  // Time-slot sequencer with parity
  // ****************************************************************
  reg  [3:0]  slot_ff;
  reg         par_ff;
  reg  [15:0] tick_ff;
  wire        tick = (tick_ff == `SSTM_SLOT_CYC - 16'd1);

  // Each slot lasts a fixed tick; parity follows the count.
  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      tick_ff <= 16'h0000;
      slot_ff <= 4'h0;
      par_ff  <= 1'b0;
    end else begin
      tick_ff <= tick ? 16'h0000 : tick_ff + 16'd1;
      if (tick) begin
        slot_ff <= slot_ff + 4'h1;
        par_ff  <= ^(slot_ff + 4'h1);
      end
    end
  end

  wire par_err = (^slot_ff) != par_ff;

  // ****************************************************************
  // Test trigger and ready handshake
  // ****************************************************************
  // Slots 0 to 4 start the five selectable tests as they end; others are idle.
  reg  [4:0]  start_ff;
  reg  [15:0] wait_ff;
  reg         nordy_ev;
  reg  [4:0]  done_ff;
  assign TEST_START = start_ff;

  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      start_ff <= 5'h00;
      wait_ff  <= 16'h0000;
      nordy_ev <= 1'b0;
      done_ff  <= 5'h00;
    end else begin
      nordy_ev <= 1'b0;
      done_ff  <= 5'h00;
      if (start_ff != 5'h00) begin
        if ((ready_s & start_ff) != 5'h00) begin
          done_ff  <= start_ff; // Ready samples results.
          start_ff <= 5'h00;
        end else if (wait_ff == `SSTM_RDY_TMO) begin
          nordy_ev <= 1'b1;
          start_ff <= 5'h00;
        end else begin
          wait_ff <= wait_ff + 16'd1;
        end
      end else if (tick && gen && slot_ff < 4'h5) begin
        start_ff <= (5'h01 << slot_ff[2:0]) & sel_en;
        wait_ff  <= 16'h0000;
      end
    end
  end

  // ****************************************************************
  // Check evaluation
  // ****************************************************************
  wire [DW-1:0] tdiff = (TEMP_SENSOR > TEMP_AMPL) ?
                        TEMP_SENSOR - TEMP_AMPL : TEMP_AMPL - TEMP_SENSOR;
  wire [AW-1:0] inv_sum  = ANGLE_MAIN + ANGLE_INV;
  wire [AW-1:0] clp_sum  = CLAMP_LO + CLAMP_HI;
  wire [AW-1:0] cord_sum = CORDIC_ANGLE + CORDIC_INV_ANGLE;
  // Limit kept in 32 bits so the product cannot overflow.
  wire [31:0] adc_lim = ({16'h0000, ADC_FS} * `SSTM_ADC_FS_PCT) / 100;

  wire [4:0] sel_fail;
  assign sel_fail[0] = done_ff[0] & (tdiff > TEMP_TOL);
  assign sel_fail[1] = done_ff[1] & (inv_sum != clp_sum);
  assign sel_fail[2] = done_ff[2] & (DIV_RESULT != DIV_EXP);
  assign sel_fail[3] = done_ff[3] & (cord_sum != {AW{1'b0}});
  assign sel_fail[4] = done_ff[4] &
                       (ANGLE_ZEROED != ANGLE_ZEROED_ALU);

  // Completion counter: a selected failure must show within 160 us.
  localparam [15:0] COMPL_CYC = `SSTM_COMPL_US * `SSTM_CLK_MHZ;
  reg  [15:0] cpl_ff;
  reg         cpl_pend_ff;
  wire        any_sel = (sel_fail != 5'h00) | nordy_ev;

  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cpl_ff      <= 16'h0000;
      cpl_pend_ff <= 1'b0;
    end else if (any_sel) begin
      cpl_pend_ff <= 1'b1;
      cpl_ff      <= 16'h0000;
    end else if (cpl_pend_ff) begin
      cpl_ff <= cpl_ff + 16'd1;
      if (flags_ff[`SSTM_F_COMPL]) cpl_pend_ff <= 1'b0;
    end
  end

  // Events in flag order; the completion flag rises one cycle later.
  wire [`SSTM_NFLAGS-1:0] ev;
  assign ev[4:0]            = sel_fail;
  assign ev[`SSTM_F_CTRL]   = pdone_s & ~pdok_s;
  assign ev[`SSTM_F_COMPL]  = cpl_pend_ff;
  assign ev[`SSTM_F_PAR]    = par_err;
  assign ev[`SSTM_F_ADC]    = ({16'h0000, ADC_RESULT} > adc_lim);
  assign ev[`SSTM_F_ADD]    = addovf_s;
  assign ev[`SSTM_F_CORD]   = cordovf_s;
  assign ev[`SSTM_F_CLAMP]  = clamp_s & ~range_s;
  assign ev[`SSTM_F_TSENS]  = tfail_s;
  assign ev[`SSTM_F_NORDY]  = nordy_ev;

  // Sticky flags; a new event wins over a clear in the same cycle.
  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      flags_ff <= {`SSTM_NFLAGS{1'b0}};
    end else begin
      flags_ff <= (flags_ff & ~clr_ff) | ev;
    end
  end
  assign FLAGS = flags_ff;

  // Fixed checks 5 to 11 honour their mask, 12 and 13 are never masked; selectable ones are gated by enables.
  wire [`SSTM_NFLAGS-1:0] eff_mask = {2'b00,
                                      mask, 5'h00};
  wire diag_req = |(flags_ff & ~eff_mask);

  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      DIAG_MODE <= 1'b0;
    end else begin
      DIAG_MODE <= diag_req;
    end
  end

  // ****************************************************************
  // Wishbone read and acknowledge
  // ****************************************************************
  // Ack one cycle after the request; unmapped reads return zero.
  always @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end else begin
      WB_ACK_O <= wb_req;
      if (wb_req && !WB_WE_I) begin
        if (WB_ADR_I == `SSTM_ADR_CFG)
          WB_DAT_O <= {16'h0000, cfg_ff};
        else if (WB_ADR_I == `SSTM_ADR_FLAGS)
          WB_DAT_O <= {18'h00000, flags_ff};
        else if (WB_ADR_I == `SSTM_ADR_SEQ)
          WB_DAT_O <= {22'h000000, par_ff, start_ff, slot_ff};
        else
          WB_DAT_O <= 32'h00000000;
      end
    end
  end

endmodule
